// *** rtl/ctm_pkg.sv ***
package ctm_pkg;

  // ***************************************************************
  // bus layout
  // ***************************************************************
  localparam int unsigned CTM_ADDR_W = 8;
  localparam logic [7:0] CTM_OFF_CTRL0 = 8'h00;
  localparam logic [7:0] CTM_OFF_CTRL1 = 8'h04;
  localparam logic [7:0] CTM_OFF_CNT_LO = 8'h08;
  localparam logic [7:0] CTM_OFF_CNT_HI = 8'h0c;
  localparam logic [7:0] CTM_OFF_CMPA_LO = 8'h10;
  localparam logic [7:0] CTM_OFF_CMPA_HI = 8'h14;
  localparam logic [7:0] CTM_OFF_FLAGS = 8'h18;

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [7:0] CTM_CTRL0_RST = 8'h00;
  localparam logic [7:0] CTM_CTRL1_RST = 8'h00;
  localparam logic [9:0] CTM_CNT_RST = 10'h000;
  localparam logic [9:0] CTM_CMPA_RST = 10'h000;
  localparam logic [7:0] CTM_BUF_RST = 8'h00;
  localparam logic [1:0] CTM_FLAGS_RST = 2'h0;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int unsigned CTM_C0_PAUSE = 7;
  localparam int unsigned CTM_C0_CKSEL = 4;
  localparam int unsigned CTM_C0_ON = 3;
  localparam int unsigned CTM_C0_RP = 0;
  localparam int unsigned CTM_C1_MODE = 6;
  localparam int unsigned CTM_C1_OFUNC = 4;
  localparam int unsigned CTM_C1_OC = 3;
  localparam int unsigned CTM_C1_POL = 2;
  localparam int unsigned CTM_C1_DPX = 1;
  localparam int unsigned CTM_C1_CLR = 0;
  localparam int unsigned CTM_FLAG_A = 0;
  localparam int unsigned CTM_FLAG_P = 1;

  // ***************************************************************
  // encodings and counts
  // ***************************************************************
  typedef enum logic [1:0] {
    CTM_MODE_CMP = 2'h0,
    CTM_MODE_UNDEF = 2'h1,
    CTM_MODE_PWM = 2'h2,
    CTM_MODE_TMR = 2'h3
  } ctm_mode_t;

  localparam logic [2:0] CTM_CK_SYS4 = 3'h0;
  localparam logic [2:0] CTM_CK_SYS = 3'h1;
  localparam logic [2:0] CTM_CK_H16 = 3'h2;
  localparam logic [2:0] CTM_CK_H64 = 3'h3;
  localparam logic [2:0] CTM_CK_SUB0 = 3'h4;
  localparam logic [2:0] CTM_CK_SUB1 = 3'h5;
  localparam logic [2:0] CTM_CK_EXT_RISE = 3'h6;
  localparam logic [2:0] CTM_CK_EXT_FALL = 3'h7;

  localparam logic [1:0] CTM_SYS4_LAST = 2'h3;
  localparam logic [5:0] CTM_H16_LAST = 6'h0f;
  localparam logic [5:0] CTM_H64_LAST = 6'h3f;
  localparam logic [10:0] CTM_FULL_SPAN = 11'h400;

  // comparator-p span: value times 128, zero means full 1024 count
  function automatic logic [10:0] ctm_p_span(input logic [2:0] rp);
    ctm_p_span = (rp == 3'h0) ? CTM_FULL_SPAN : {1'b0, rp, 7'h00};
  endfunction

endpackage

// *** rtl/ctm_timer.sv ***
`timescale 1ns/1ps
// Operation
// - ten-bit up counter steps on the chosen internal tick or pin edge
// - comparator p checks three bits against counter bits 9..7, a checks all ten
// - on-bit rising clears counter; on-bit low stops and keeps value
// - pause holds the counter; release continues from the held value
// - clock select picks sys/4, sys, high/16, high/64, sub, pin rise or fall
// - comparator p period is value times 128 clocks, zero gives 1024
// - mode field: 00 compare output, 10 pwm, 11 timer, 01 undefined
// - compare mode: a-match keeps, lows, highs or toggles the pin
// - compare mode: on-bit rising loads initial pin level from output control
// - forced level equal to present level gives no visible pin change
// - pwm output function: 00 inactive, 01 active, 10 waveform, 11 undefined
// - pwm output control picks active level; unused in timer mode
// - polarity bit inverts the pin; unused in timer mode
// - swap bit: 0 p period a duty, 1 a period p duty
// - clear select high clears on a-match or overflow, low on p-match
// - clear select is ignored in pwm mode
// - automatic clears by a match raise a timer request; overflow clears do not
// - counter is a read-only pair, comparator a a read/write pair
// - low-byte write fills buffer; high-byte write commits both bytes
// - high-byte read latches low byte into buffer; low read returns it
// - outside pwm mode, with a as clear source the p flag is never set
module ctm_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ctm_pkg::CTM_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic high_clock_tick,
  input wire logic sub_clock_tick,
  input wire logic external_clock_pin,
  output logic waveform_output_pin,
  output logic waveform_output_en,
  output logic timer_irq
);
  import ctm_pkg::*;

  // ***************************************************************
  // state
  // ***************************************************************
  logic [7:0] ctrl0_q;
  logic [7:0] ctrl1_q;
  logic [9:0] cnt_q;
  logic [9:0] cmpa_q;
  logic [7:0] byte_buf_q;
  logic [1:0] flags_q;
  logic on_prev_q;
  logic [1:0] sys_div_q;
  logic [5:0] h_div_q;
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_s3_q;
  logic lvl_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic pin_q;
  logic pin_en_q;
  logic irq_q;

  // ***************************************************************
  // field decode
  // ***************************************************************
  logic pause;
  logic on;
  logic [2:0] clk_sel;
  logic [2:0] rp;
  ctm_mode_t mode;
  logic [1:0] ofunc;
  logic oc;
  logic pol;
  logic dpx;
  logic clr_sel;
  logic pwm_mode;
  logic cmp_mode;

  assign pause = ctrl0_q[CTM_C0_PAUSE];
  assign on = ctrl0_q[CTM_C0_ON];
  assign clk_sel = ctrl0_q[CTM_C0_CKSEL +: 3];
  assign rp = ctrl0_q[CTM_C0_RP +: 3];
  assign mode = ctm_mode_t'(ctrl1_q[CTM_C1_MODE +: 2]);
  assign ofunc = ctrl1_q[CTM_C1_OFUNC +: 2];
  assign oc = ctrl1_q[CTM_C1_OC];
  assign pol = ctrl1_q[CTM_C1_POL];
  assign dpx = ctrl1_q[CTM_C1_DPX];
  assign clr_sel = ctrl1_q[CTM_C1_CLR];
  assign pwm_mode = (mode == CTM_MODE_PWM);
  assign cmp_mode = (mode == CTM_MODE_CMP);

  // ***************************************************************
  // apb slave, no wait state; every answer is registered in the setup cycle so it comes from a flop
  // ***************************************************************
  logic setup;
  logic done;
  logic wr_done;
  logic rd_done;
  logic addr_ok;
  logic [31:0] rd_mux;

  assign setup = psel & ~penable;
  assign done = psel & penable & pready_q;
  assign wr_done = done & pwrite;
  assign rd_done = done & ~pwrite;

  always_comb begin
    rd_mux = 32'h0000_0000;
    addr_ok = 1'b1;
    unique case (paddr)
      CTM_OFF_CTRL0: rd_mux[7:0] = ctrl0_q;
      CTM_OFF_CTRL1: rd_mux[7:0] = ctrl1_q;
      CTM_OFF_CNT_LO: rd_mux[7:0] = byte_buf_q;
      CTM_OFF_CNT_HI: rd_mux[1:0] = cnt_q[9:8];
      CTM_OFF_CMPA_LO: rd_mux[7:0] = byte_buf_q;
      CTM_OFF_CMPA_HI: rd_mux[1:0] = cmpa_q[9:8];
      CTM_OFF_FLAGS: rd_mux[1:0] = flags_q;
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      if (setup) begin
        pready_q <= 1'b1;
        pslverr_q <= ~addr_ok;
        prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      end else if (done) begin
        pready_q <= 1'b0;
        pslverr_q <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // control registers
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_q <= CTM_CTRL0_RST;
      ctrl1_q <= CTM_CTRL1_RST;
    end else if (clk_en && wr_done) begin
      if (paddr == CTM_OFF_CTRL0) begin
        ctrl0_q <= pwdata[7:0];
      end
      if (paddr == CTM_OFF_CTRL1) begin
        ctrl1_q <= pwdata[7:0];
      end
    end
  end

  // ***************************************************************
  // byte pairs through the shared buffer
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmpa_q <= CTM_CMPA_RST;
      byte_buf_q <= CTM_BUF_RST;
    end else if (clk_en) begin
      if (wr_done && paddr == CTM_OFF_CMPA_LO) begin
        byte_buf_q <= pwdata[7:0];
      end else if (wr_done && paddr == CTM_OFF_CMPA_HI) begin
        cmpa_q <= {pwdata[1:0], byte_buf_q};
      end else if (rd_done && paddr == CTM_OFF_CNT_HI) begin
        byte_buf_q <= cnt_q[7:0];
      end else if (rd_done && paddr == CTM_OFF_CMPA_HI) begin
        byte_buf_q <= cmpa_q[7:0];
      end
    end
  end

  // ***************************************************************
  // counter clock selection
  // ***************************************************************
  logic tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_div_q <= 2'h0;
      h_div_q <= 6'h00;
    end else if (clk_en) begin
      sys_div_q <= sys_div_q + 2'h1;
      if (high_clock_tick) begin
        h_div_q <= h_div_q + 6'h01;
      end
    end
  end

  // pin is asynchronous; only the second and third stages feed logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else if (clk_en) begin
      ext_s1_q <= external_clock_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  always_comb begin
    unique case (clk_sel)
      CTM_CK_SYS4: tick = (sys_div_q == CTM_SYS4_LAST);
      CTM_CK_SYS: tick = 1'b1;
      CTM_CK_H16: tick = high_clock_tick & (h_div_q[3:0] == CTM_H16_LAST[3:0]);
      CTM_CK_H64: tick = high_clock_tick & (h_div_q == CTM_H64_LAST);
      CTM_CK_SUB0: tick = sub_clock_tick;
      CTM_CK_SUB1: tick = sub_clock_tick;
      CTM_CK_EXT_RISE: tick = ext_s2_q & ~ext_s3_q;
      CTM_CK_EXT_FALL: tick = ~ext_s2_q & ext_s3_q;
    endcase
  end

  // ***************************************************************
  // counter and comparators
  // ***************************************************************
  logic on_rise;
  logic count_en;
  logic [10:0] nxt;
  logic [10:0] p_span;
  logic a_hit;
  logic p_hit;
  logic ovf;
  logic clr_evt;
  logic set_a;
  logic set_p;

  assign on_rise = on & ~on_prev_q;
  assign count_en = on & ~pause & tick;
  assign nxt = {1'b0, cnt_q} + 11'h001;
  assign p_span = ctm_p_span(rp);
  // matches are taken on the step that would reach the compare value
  assign a_hit = count_en & (nxt == {1'b0, cmpa_q});
  assign p_hit = count_en & (nxt == p_span);
  assign ovf = count_en & nxt[10];
  assign clr_evt = (pwm_mode ? dpx : clr_sel) ? (a_hit | ovf) : p_hit;
  assign set_a = a_hit;
  assign set_p = p_hit & (pwm_mode | ~clr_sel);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_prev_q <= 1'b0;
      cnt_q <= CTM_CNT_RST;
    end else if (clk_en) begin
      on_prev_q <= on;
      if (on_rise) begin
        cnt_q <= CTM_CNT_RST;
      end else if (count_en) begin
        cnt_q <= clr_evt ? CTM_CNT_RST : nxt[9:0];
      end
    end
  end

  // ***************************************************************
  // match flags and request pulse
  // ***************************************************************
  logic [1:0] flag_clr;

  assign flag_clr = (wr_done && paddr == CTM_OFF_FLAGS) ? pwdata[1:0] : 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= CTM_FLAGS_RST;
      irq_q <= 1'b0;
    end else if (clk_en) begin
      // a set in the clearing cycle wins
      flags_q <= (flags_q & ~flag_clr) | {set_p, set_a};
      irq_q <= set_a | set_p;
    end
  end

  // ***************************************************************
  // output pin
  // ***************************************************************
  logic [10:0] duty_span;
  logic pwm_act;
  logic pwm_lvl;

  assign duty_span = dpx ? p_span : {1'b0, cmpa_q};
  // counter never reaches a duty at or above the period, so it stays active
  assign pwm_act = ({1'b0, cnt_q} < duty_span);

  always_comb begin
    unique case (ofunc)
      2'h0: pwm_lvl = ~oc;
      2'h1: pwm_lvl = oc;
      2'h2: pwm_lvl = pwm_act ? oc : ~oc;
      2'h3: pwm_lvl = ~oc;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_q <= 1'b0;
    end else if (clk_en && cmp_mode) begin
      if (on_rise) begin
        lvl_q <= oc;
      end else if (a_hit) begin
        // forcing the present level leaves the pin unchanged
        unique case (ofunc)
          2'h0: lvl_q <= lvl_q;
          2'h1: lvl_q <= 1'b0;
          2'h2: lvl_q <= 1'b1;
          2'h3: lvl_q <= ~lvl_q;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b0;
      pin_en_q <= 1'b0;
    end else if (clk_en) begin
      pin_en_q <= cmp_mode | pwm_mode;
      if (cmp_mode) begin
        pin_q <= lvl_q ^ pol;
      end else if (pwm_mode) begin
        pin_q <= pwm_lvl ^ pol;
      end else begin
        pin_q <= 1'b0;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign waveform_output_pin = pin_q;
  assign waveform_output_en = pin_en_q;
  assign timer_irq = irq_q;

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cmp_start;
    clk_en && on_rise && cmp_mode ##1 clk_en && cmp_mode;
  endsequence

  chk_on_rise_clear: assert property (clk_en && on_rise |=> cnt_q == 10'h000)
    else $error("counter not cleared by on-bit rise");
  chk_off_holds: assert property (clk_en && !on |=> $stable(cnt_q))
    else $error("counter moved while off");
  chk_pause_holds: assert property (clk_en && pause && !on_rise |=> $stable(cnt_q))
    else $error("counter moved while paused");
  chk_count_step: assert property (clk_en && count_en && !clr_evt && !on_rise
      |=> cnt_q == 10'($past(cnt_q) + 10'h001))
    else $error("counter did not step by one");
  chk_p_period: assert property (clk_en && !pwm_mode && !clr_sel && !on_rise && count_en
      && nxt == ctm_p_span(rp) |=> cnt_q == 10'h000 && flags_q[CTM_FLAG_P])
    else $error("comparator p period wrong");
  chk_a_clear: assert property (clk_en && !pwm_mode && clr_sel && a_hit && !on_rise
      |=> cnt_q == 10'h000 && flags_q[CTM_FLAG_A])
    else $error("comparator a did not clear");
  chk_p_flag_block: assert property (clk_en && !pwm_mode && clr_sel && !flags_q[CTM_FLAG_P]
      |=> !flags_q[CTM_FLAG_P])
    else $error("p flag set with a as clear source");
  chk_cmp_init: assert property (s_cmp_start |=> waveform_output_pin == ($past(oc, 2) ^
      $past(pol)))
    else $error("initial pin level wrong");
  chk_toggle_pin: assert property (clk_en && cmp_mode && a_hit && !on_rise && ofunc == 2'h3
      |=> lvl_q != $past(lvl_q))
    else $error("toggle did not toggle");
  chk_pwm_active: assert property (clk_en && pwm_mode && ofunc == 2'h1
      |=> waveform_output_pin == ($past(oc) ^ $past(pol)))
    else $error("pwm forced active level wrong");
  chk_timer_pin: assert property (clk_en && mode == CTM_MODE_TMR
      |=> !waveform_output_pin && !waveform_output_en)
    else $error("pin used in timer mode");
  chk_flag_sticky: assert property (clk_en && flags_q[CTM_FLAG_A] && !flag_clr[CTM_FLAG_A]
      |=> flags_q[CTM_FLAG_A])
    else $error("flag dropped without clear");
  chk_clear_request: assert property (clk_en && clr_evt
      && (a_hit || (p_hit && (pwm_mode || !clr_sel)))
      |=> timer_irq)
    else $error("no request on automatic clear");
  chk_pair_commit: assert property (clk_en && wr_done && paddr == CTM_OFF_CMPA_HI
      |=> cmpa_q == {$past(pwdata[1:0]), $past(byte_buf_q)})
    else $error("comparator a pair commit wrong");
  chk_read_latch: assert property (clk_en && rd_done && paddr == CTM_OFF_CNT_HI
      |=> byte_buf_q == $past(cnt_q[7:0]))
    else $error("low byte not latched");
  chk_apb_answer: assert property (clk_en && setup |=> pready)
    else $error("no answer after setup");

endmodule

// *** verif/ctm_pin_model.sv ***
`timescale 1ns/1ps
// ***************************************************************
// external clock source
// ***************************************************************
module ctm_pin_model (
  input wire logic clk,
  input wire logic run,
  output logic ext_pin,
  output int rises
);
  logic [2:0] div_q;
  initial begin
    ext_pin = 1'b0;
    div_q = 3'h0;
    rises = 0;
  end
  // a driven source: the level simply holds between bursts
  always @(posedge clk) begin
    if (run) begin
      div_q <= div_q + 3'h1;
      if (div_q == 3'h7) begin
        ext_pin <= ~ext_pin;
        if (!ext_pin) rises <= rises + 1;
      end
    end
  end
endmodule

// *** verif/compact_timer_module_tb.sv ***
`timescale 1ns/1ps
module compact_timer_module_tb;
  import ctm_pkg::*;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, cyc, lf;
  logic high_clock_tick, sub_clock_tick, ext_pin, wave_pin, wave_en, timer_irq, run;
  int errors, check_count, irqs, rises;

  ctm_timer i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .high_clock_tick(high_clock_tick),
    .sub_clock_tick(sub_clock_tick), .external_clock_pin(ext_pin),
    .waveform_output_pin(wave_pin), .waveform_output_en(wave_en), .timer_irq(timer_irq));
  ctm_pin_model i_pin (.clk(pclk), .run(run), .ext_pin(ext_pin), .rises(rises));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic cmp_exp(input logic [1:0] f, input logic oc);
    case (f)
      2'h0: cmp_exp = oc;
      2'h1: cmp_exp = 1'b0;
      2'h2: cmp_exp = 1'b1;
      default: cmp_exp = ~oc;
    endcase
  endfunction

  // nominal counts over the 512 cycle window of the clock select sweep
  function automatic int exp_cnt(input logic [2:0] s, input int edges);
    case (s)
      CTM_CK_SYS4: exp_cnt = 128;
      CTM_CK_SYS: exp_cnt = 512;
      CTM_CK_H16: exp_cnt = 16;
      CTM_CK_H64: exp_cnt = 4;
      CTM_CK_SUB0, CTM_CK_SUB1: exp_cnt = 128;
      default: exp_cnt = edges;
    endcase
  endfunction

  task automatic summarize;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rdat, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      summarize();
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    xfer(1'b0, a, 32'h0, d, e);
  endtask

  // high first, so the low byte comes from the latched buffer
  task automatic rd10(input logic [7:0] hi, output logic [9:0] v);
    logic [31:0] h, l;
    rd(hi, h);
    rd(hi - 8'h4, l);
    v = {h[1:0], l[7:0]};
  endtask

  task automatic start(input logic [7:0] c1, input logic [7:0] c0);
    wr(CTM_OFF_CTRL0, 32'h0);
    wr(CTM_OFF_FLAGS, 32'h3);
    wr(CTM_OFF_CTRL1, {24'h0, c1});
    wr(CTM_OFF_CTRL0, {24'h0, c0});
  endtask

  task automatic pwm(input logic dpx, input logic [9:0] a, input int win, input int e);
    int hi;
    hi = 0;
    wr(CTM_OFF_CMPA_LO, {24'h0, a[7:0]});
    wr(CTM_OFF_CMPA_HI, {30'h0, a[9:8]});
    start({6'b101010, dpx, 1'b1}, 8'h19);
    repeat (win + 10) @(posedge pclk);
    repeat (win) begin
      @(posedge pclk);
      hi += (wave_pin === 1'b1);
    end
    chk("pwm high cycles", e, hi);
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 32'h1;
    high_clock_tick <= cyc[0];
    sub_clock_tick <= (cyc[1:0] == 2'h0);
    if (timer_irq === 1'b1) irqs <= irqs + 1;
    if (cyc == 32'd40000) begin
      errors++;
      summarize();
    end
  end

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    logic [31:0] r;
    logic [9:0] v, v0;
    logic e;
    int ex, tol, r0;
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    high_clock_tick = 1'b0;
    sub_clock_tick = 1'b0;
    run = 1'b0;
    cyc = 32'h0;
    lf = 32'h0ff7;
    errors = 0;
    check_count = 0;
    irqs = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 28; a += 4) begin
      rd(a[7:0], r);
      chk("reset value", 32'h0, r);
    end
    xfer(1'b0, 8'h1c, 32'h0, r, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    lf = lfsr(lf);
    wr(CTM_OFF_CTRL1, {24'h0, lf[7:0]});
    rd(CTM_OFF_CTRL1, r);
    chk("ctrl1 readback", {24'h0, lf[7:0]}, r);
    wr(CTM_OFF_CTRL1, 32'h0);
    wr(CTM_OFF_CNT_LO, 32'hff);
    wr(CTM_OFF_CNT_HI, 32'h3);
    rd10(CTM_OFF_CNT_HI, v);
    chk("counter write ignored", 32'h0, {22'h0, v});
    start(8'h00, 8'h19);
    repeat (200) @(posedge pclk);
    rd(CTM_OFF_FLAGS, r);
    chk("p match flag", 32'h2, r);
    chk("irq seen", 32'h1, {31'h0, irqs > 0});
    wr(CTM_OFF_FLAGS, 32'h3);
    rd(CTM_OFF_FLAGS, r);
    chk("flags cleared", 32'h0, r);
    wr(CTM_OFF_CTRL0, 32'h11);
    rd10(CTM_OFF_CNT_HI, v0);
    repeat (20) @(posedge pclk);
    rd10(CTM_OFF_CNT_HI, v);
    chk("off keeps count", {22'h0, v0}, {22'h0, v});
    wr(CTM_OFF_CTRL0, 32'h99);
    rd10(CTM_OFF_CNT_HI, v);
    chk("on rise clears", 32'h0, {22'h0, v});
    repeat (20) @(posedge pclk);
    rd10(CTM_OFF_CNT_HI, v);
    chk("pause holds", 32'h0, {22'h0, v});
    wr(CTM_OFF_CTRL0, 32'h19);
    // a frozen clock enable must not let the count run past the window
    clk_en <= 1'b0;
    repeat (30) @(posedge pclk);
    clk_en <= 1'b1;
    repeat (20) @(posedge pclk);
    rd10(CTM_OFF_CNT_HI, v);
    chk("resume count", 32'h1, {31'h0, v >= 10'd20 && v <= 10'd40});
    for (int s = 0; s < 8; s++) begin
      r0 = rises;
      start(8'h00, {1'b0, s[2:0], 4'h8});
      run <= 1'b1;
      repeat (512) @(posedge pclk);
      run <= 1'b0;
      wr(CTM_OFF_CTRL0, {25'h0, s[2:0], 4'h0});
      rd10(CTM_OFF_CNT_HI, v);
      ex = exp_cnt(s[2:0], rises - r0);
      tol = ex / 64 + 2;
      chk("clock select count", ex, (int'(v) >= ex - tol && int'(v) <= ex + tol) ? ex : v);
    end
    lf = lfsr(lf);
    v0 = lf[9:0];
    wr(CTM_OFF_CMPA_LO, {24'h0, v0[7:0]});
    wr(CTM_OFF_CMPA_HI, {30'h0, v0[9:8]});
    rd10(CTM_OFF_CMPA_HI, v);
    chk("cmp a pair", {22'h0, v0}, {22'h0, v});
    wr(CTM_OFF_CMPA_LO, {24'h0, ~v0[7:0]});
    rd10(CTM_OFF_CMPA_HI, v);
    chk("low write buffered only", {22'h0, v0}, {22'h0, v});
    wr(CTM_OFF_CMPA_LO, 32'hc8);
    wr(CTM_OFF_CMPA_HI, 32'h0);
    for (int k = 0; k < 8; k++) begin
      start({2'h0, k[2:1], k[0], 1'b0, 1'b0, 1'b1}, 8'h19);
      repeat (4) @(posedge pclk);
      chk("initial level", {31'h0, k[0]}, {31'h0, wave_pin});
      chk("output enable", 32'h1, {31'h0, wave_en});
      repeat (250) @(posedge pclk);
      chk("match action", {31'h0, cmp_exp(k[2:1], k[0])}, {31'h0, wave_pin});
      rd(CTM_OFF_FLAGS, r);
      chk("a clears flags", 32'h1, r);
    end
    for (int k = 0; k < 8; k++) begin
      start({3'b100, k[2], k[1], k[0], 2'b00}, 8'h19);
      repeat (4) @(posedge pclk);
      chk("pwm fixed level", {31'h0, (k[2] ? k[1] : ~k[1]) ^ k[0]}, {31'h0, wave_pin});
    end
    pwm(1'b0, 10'd32, 128, 32);
    pwm(1'b0, 10'd200, 128, 128);
    pwm(1'b1, 10'd300, 300, 128);
    lf = lfsr(lf);
    pwm(1'b0, {3'h0, lf[6:0]}, 128, int'(lf[6:0]));
    start(8'hc0, 8'h19);
    repeat (3) @(posedge pclk);
    chk("timer mode enable", 32'h0, {31'h0, wave_en});
    repeat (200) @(posedge pclk);
    rd(CTM_OFF_FLAGS, r);
    // comparator a still holds the random duty, so unless it is zero it matches before p clears
    chk("timer mode flag", {30'h0, 1'b1, lf[6:0] != 7'h00}, r);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rd(CTM_OFF_CTRL1, r);
    chk("mid-run reset", 32'h0, r);
    start(8'h40, 8'h00);
    repeat (3) @(posedge pclk);
    chk("undefined mode enable", 32'h0, {31'h0, wave_en});
    summarize();
  end
endmodule
